// file: udt_pkg.sv
// shared constants, register map and carrier types for the up/down timer
package udt_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] UDT_OFS_CTRL  = 8'h00;
   localparam logic [7:0] UDT_OFS_MODE  = 8'h04;
   localparam logic [7:0] UDT_OFS_CNT   = 8'h08;
   localparam logic [7:0] UDT_OFS_RLD   = 8'h0C;

   // control register field positions
   localparam int UDT_CTL_CRS = 0;
   localparam int UDT_CTL_CSEL = 1;
   localparam int UDT_CTL_RUN = 2;
   localparam int UDT_CTL_EXEN = 3;
   localparam int UDT_CTL_TXC = 4;
   localparam int UDT_CTL_RXC = 5;
   localparam int UDT_CTL_EXF = 6;
   localparam int UDT_CTL_OVF = 7;

   // mode register field positions
   localparam int UDT_MOD_DOWN_COUNT_ENABLE = 0;
   localparam int UDT_MOD_CKOE = 1;

   // reset values and the count top loaded on a down wrap
   localparam logic [7:0]  UDT_CTRL_RST = 8'h00;
   localparam logic [1:0]  UDT_MODE_RST = 2'h0;
   localparam logic [15:0] UDT_CNT_RST  = 16'h0000;
   localparam logic [15:0] UDT_RLD_RST  = 16'h0000;
   localparam logic [15:0] UDT_CNT_TOP  = 16'hFFFF;

   // prescaler counts in core clocks
   localparam int UDT_TMR_DIV = 12;
   localparam int UDT_CKO_DIV = 2;

   typedef enum logic [1:0] {
      UDT_M_RELOAD,
      UDT_M_CAPTURE,
      UDT_M_BAUD
   } udt_mode_e;

   typedef struct packed {
      logic        ovf;
      logic        exf;
      logic        rxc;
      logic        txc;
      logic        exen;
      logic        run;
      logic        csel;
      logic        crs;
   } udt_ctrl_s;

   typedef struct packed {
      logic        ckoe;
      logic        down_count_enable;
   } udt_modr_s;

endpackage

// file: udt_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module udt_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// file: udt_prescale.sv
// free-running divider producing a one-cycle enable every DIV clocks
`timescale 1ns/10ps
module udt_prescale #(
   parameter int DIV = 12
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic clr,
   output logic      tick
);
   localparam int CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (clr) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_r == LAST);
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
      end
   end
endmodule

// file: udt_timer.sv
// up/down auto-reload timer with clock output, apb register slave
// ----------------------------------------------------------------
// How it works
// - count is two chained bytes, low byte carries into high byte
// - counter select picks clock/12 tick (clock/2 in baud and clock-out) or falling count-pin edge
// - counting advances only while run control is set
// - mode from rx/tx clock selects and capture/reload select
// - down-count enable clear gives plain up-only auto-reload
// - down-count enable set in reload mode: direction pin high up, low down
// - up rollover from FFFF sets flag, interrupts, loads reload value
// - down count equal to reload sets flag and loads FFFF
// - up/down: extension flag toggles each wrap, never interrupts
// - clock-out mode gives a 50 percent duty clock
// - clock-out mode advances count at clock divided by two
// - clock-out overflow reloads and raises no interrupt
// - clock-out pin toggles on each overflow: f/(4*(65536-reload))
// - clock-out drives the count pin as an output
// - baud generation and clock-out share one reload register
// - mode register holds clock-out enable bit 1, down enable bit 0
// - overflow flag set only with both baud selects zero
// - counter mode counts falling edges; select zero for clock-out
// ----------------------------------------------------------------
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module udt_timer
   import udt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_input_pin_i,
   output logic             count_input_pin_o,
   output logic             count_input_pin_oe,
   input  wire logic        direction_pin,
   output logic             ovf_irq,
   output logic             baud_tick
);
   import udt_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   udt_ctrl_s   ctrl_r;
   udt_modr_s   mode_r;
   logic [7:0]  count_low_byte_r;
   logic [7:0]  count_high_byte_r;
   logic [15:0] reload_r;
   logic        cko_r;
   logic        pin_q_r;
   logic        pin_s;
   logic        dir_s;
   logic        div12_tick;
   logic        div2_tick;
   logic        cko_mode;

   // ----------------------------------------------------------------
   // pin synchronisers and prescalers
   // ----------------------------------------------------------------
   udt_sync #(.W(2)) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      ({count_input_pin_i, direction_pin}),
      .q      ({pin_s, dir_s})
   );

   // prescalers held in reset while stopped so each start is aligned
   udt_prescale #(.DIV(UDT_TMR_DIV)) u_div12 (
      .clk    (clk),
      .arst_n (arst_n),
      .clr    (!ctrl_r.run),
      .tick   (div12_tick)
   );

   udt_prescale #(.DIV(UDT_CKO_DIV)) u_div2 (
      .clk    (clk),
      .arst_n (arst_n),
      .clr    (!ctrl_r.run),
      .tick   (div2_tick)
   );

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   // capture is not built: with its select set the timer counts as up-only reload
   udt_mode_e mode;
   wire baud_sel = ctrl_r.rxc | ctrl_r.txc;
   assign mode = baud_sel ? UDT_M_BAUD :
                 ctrl_r.crs ? UDT_M_CAPTURE : UDT_M_RELOAD;

   // clock-out only valid with counter select clear
   assign cko_mode = mode_r.ckoe & ~ctrl_r.csel;

   wire pin_fall = pin_q_r & ~pin_s;
   wire src_tick = ctrl_r.csel ? pin_fall : div12_tick;
   wire baud_fast = (mode == UDT_M_BAUD) & ~ctrl_r.csel;
   wire fast_clk = cko_mode | baud_fast;
   wire cnt_tick = ctrl_r.run &
                   (fast_clk ? div2_tick : src_tick);

   wire updown   = mode_r.down_count_enable & (mode == UDT_M_RELOAD);
   wire count_dn = updown & ~dir_s;

   wire [15:0] count = {count_high_byte_r, count_low_byte_r};
   wire        low_carry = (count_low_byte_r == 8'hFF);
   wire        at_top    = low_carry & (count_high_byte_r == 8'hFF);
   wire        at_floor  = (count == reload_r);

   wire up_wrap = cnt_tick & ~count_dn & at_top;
   wire dn_wrap = cnt_tick & count_dn & at_floor;
   wire wrap    = up_wrap | dn_wrap;

   // clock-out and baud overflows never flag
   wire flag_ev = wrap & ~baud_sel & ~cko_mode;

   // ----------------------------------------------------------------
   // next count
   // ----------------------------------------------------------------
   logic [7:0] low_nxt;
   logic [7:0] high_nxt;
   always_comb begin
      low_nxt  = count_low_byte_r;
      high_nxt = count_high_byte_r;
      if (cnt_tick) begin
         if (up_wrap) begin
            // all wrapping modes share the one reload value
            {high_nxt, low_nxt} = reload_r;
         end else if (dn_wrap) begin
            {high_nxt, low_nxt} = UDT_CNT_TOP;
         end else if (count_dn) begin
            low_nxt = count_low_byte_r - 8'h01;
            if (count_low_byte_r == 8'h00) begin
               high_nxt = count_high_byte_r - 8'h01;
            end
         end else begin
            low_nxt = count_low_byte_r + 8'h01;
            if (low_carry) begin
               high_nxt = count_high_byte_r + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // writes land only at the edge where pready is seen high, so the
   // wait-state cycle never applies a request the master still holds
   wire acc     = psel & penable;
   wire wr      = acc & pwrite & pready;
   wire hit_ctl = (paddr == UDT_OFS_CTRL);
   wire hit_mod = (paddr == UDT_OFS_MODE);
   wire hit_cnt = (paddr == UDT_OFS_CNT);
   wire hit_rld = (paddr == UDT_OFS_RLD);
   wire mapped  = hit_ctl | hit_mod | hit_cnt | hit_rld;

   wire wr_ctl  = wr & hit_ctl & pstrb[0];
   wire wr_mod  = wr & hit_mod & pstrb[0];
   wire wr_clo  = wr & hit_cnt & pstrb[0];
   wire wr_chi  = wr & hit_cnt & pstrb[1];
   wire wr_rlo  = wr & hit_rld & pstrb[0];
   wire wr_rhi  = wr & hit_rld & pstrb[1];

   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_ctl) begin
         rdata[7:0] = ctrl_r;
      end else if (hit_mod) begin
         rdata[1:0] = mode_r;
      end else if (hit_cnt) begin
         rdata[15:0] = count;
      end else if (hit_rld) begin
         rdata[15:0] = reload_r;
      end
   end

   // ----------------------------------------------------------------
   // control and flags; hardware set wins over software clear
   // ----------------------------------------------------------------
   udt_ctrl_s ctrl_nxt;
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctl) begin
         ctrl_nxt = udt_ctrl_s'(pwdata[7:0]);
      end
      if (flag_ev) begin
         ctrl_nxt.ovf = 1'b1;
      end
      if (wrap & updown) begin
         ctrl_nxt.exf = ~ctrl_r.exf;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= udt_ctrl_s'(UDT_CTRL_RST);
         mode_r <= udt_modr_s'(UDT_MODE_RST);
      end else begin
         ctrl_r <= ctrl_nxt;
         if (wr_mod) begin
            mode_r <= udt_modr_s'(pwdata[1:0]);
         end
      end
   end

   // ----------------------------------------------------------------
   // count and reload bytes; a bus write overrides a counting step
   // ----------------------------------------------------------------
   wire [7:0] low_load  = wr_clo ? pwdata[7:0]  : low_nxt;
   wire [7:0] high_load = wr_chi ? pwdata[15:8] : high_nxt;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_low_byte_r <= UDT_CNT_RST[7:0];
      end else begin
         count_low_byte_r <= low_load;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_high_byte_r <= UDT_CNT_RST[15:8];
      end else begin
         count_high_byte_r <= high_load;
      end
   end

   // one reload pair feeds reload, clock-out and baud overflows alike
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reload_r <= UDT_RLD_RST;
      end else begin
         if (wr_rlo) begin
            reload_r[7:0] <= pwdata[7:0];
         end
         if (wr_rhi) begin
            reload_r[15:8] <= pwdata[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // clock-out pin and edge history
   // ----------------------------------------------------------------
   // history starts low, so a pin idling high after reset shows a
   // rise first and never a false falling edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q_r <= 1'b0;
      end else begin
         pin_q_r <= pin_s;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cko_r              <= 1'b0;
         count_input_pin_o  <= 1'b0;
         count_input_pin_oe <= 1'b0;
      end else begin
         // toggle per overflow gives the even duty cycle
         if (cko_mode & up_wrap) begin
            cko_r <= ~cko_r;
         end
         count_input_pin_o  <= cko_r;
         count_input_pin_oe <= cko_mode;
      end
   end

   // ----------------------------------------------------------------
   // bus answer and system outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // one wait state: answer registered in the first access cycle
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         prdata  <= rdata;
      end
   end

   // request mirrors the flag, so a software clear drops it at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_irq   <= 1'b0;
         baud_tick <= 1'b0;
      end else begin
         ovf_irq   <= ctrl_nxt.ovf;
         baud_tick <= wrap & baud_sel;
      end
   end

endmodule

// file: udt_timer_asserts.sv
// port-level checker for the up/down timer
`timescale 1ns/10ps
module udt_timer_asserts (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        count_input_pin_i,
   input wire logic        count_input_pin_o,
   input wire logic        count_input_pin_oe,
   input wire logic        direction_pin,
   input wire logic        ovf_irq,
   input wire logic        baud_tick
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   apb_one_wait_a: assert property (
      psel && $rose(penable) |=> pready) else $error("pready late");
   ready_pulse_a: assert property (
      pready |-> psel && penable && $past(penable) ##1 !pready)
      else $error("pready not a one cycle pulse");
   err_data_a: assert property (
      pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
   cko_pin_a: assert property (
      $changed(count_input_pin_o) |-> count_input_pin_oe)
      else $error("clock out toggled undriven");
   cko_duty_a: assert property (
      $changed(count_input_pin_o) |=> $stable(count_input_pin_o))
      else $error("clock out half period too short");
   cko_noirq_a: assert property (
      count_input_pin_oe |-> !$rose(ovf_irq)) else $error("clock out irq");
   baud_noflag_a: assert property (
      baud_tick |-> !$rose(ovf_irq)) else $error("flag set in baud use");
   flag_hold_a: assert property (
      ovf_irq && !(psel && penable && pwrite) |=> ovf_irq)
      else $error("flag dropped without software");
endmodule

bind udt_timer udt_timer_asserts CHK (
   .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_input_pin_i(count_input_pin_i),
   .count_input_pin_o(count_input_pin_o),
   .count_input_pin_oe(count_input_pin_oe),
   .direction_pin(direction_pin), .ovf_irq(ovf_irq),
   .baud_tick(baud_tick)
);

// file: udt_pin_model.sv
// far-side model of the count and direction pins
`timescale 1ns/10ps
module udt_pin_model (
   input  wire logic clk,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output logic      pin_lvl,
   output logic      dir_lvl
);
   logic drv_r;
   // released pin idles high through its pull-up
   assign pin_lvl = pin_oe ? pin_o : drv_r;
   initial begin
      drv_r = 1'b1;
      dir_lvl = 1'b1;
   end
   task automatic pulse(input int n, input int w);
      repeat (n) begin
         @(posedge clk) drv_r <= 1'b0;
         repeat (w) @(posedge clk);
         drv_r <= 1'b1;
         repeat (w) @(posedge clk);
      end
   endtask
   task automatic dir(input logic up);
      @(posedge clk) dir_lvl <= up;
   endtask
endmodule

// file: tb.sv
// self-checking bench for the up/down timer
`timescale 1ns/10ps
module tb;
   import udt_pkg::*;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic        pin_lvl, pin_o, pin_oe, dir_lvl, ovf_irq, baud_tick, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_v, seed;
   logic [15:0] rl;
   int          err_total, checks_done, n, ticks, np;

   udt_timer DUT (
      .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_input_pin_i(pin_lvl), .count_input_pin_o(pin_o),
      .count_input_pin_oe(pin_oe), .direction_pin(dir_lvl),
      .ovf_irq(ovf_irq), .baud_tick(baud_tick)
   );
   udt_pin_model PM (
      .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_lvl(pin_lvl), .dir_lvl(dir_lvl)
   );

   always #2 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // reference count step
   function automatic int step(int c, int r, bit up);
      if (up) return (c == 65535) ? r : c + 1;
      return (c == r) ? 65535 : c - 1;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_v, e);
   endtask
   // run model to the wrap, wait for the flag, stop, compare count
   task automatic wrap(input int c, input int r, input bit up,
                       input logic [31:0] ef);
      ticks = 1;
      while (up ? c != 65535 : c != r) begin
         c = step(c, r, up);
         ticks++;
      end
      c = step(c, r, up);
      n = 0;
      while (ovf_irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, ovf_irq}, 32'h1);
      rd(UDT_OFS_CTRL, ef);
      wr(UDT_OFS_CTRL, 32'h0);
      rd(UDT_OFS_CNT, c);
   endtask
   task automatic hold(input logic v);
      n = 0;
      while (pin_o === v && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #60000;
      err_total++;
      close_out;
   end

   initial begin
      {clk, arst_n, psel, penable, pwrite} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      err_total = 0;
      checks_done = 0;
      seed = 32'h5921;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rd(UDT_OFS_CTRL, 32'h0);
      rd(UDT_OFS_MODE, 32'h0);
      rd(8'h10, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("test reset done");
      seed = lfsr(seed);
      rl = {1'b0, seed[14:0]};
      PM.dir(1'b0);
      wr(UDT_OFS_RLD, {16'h0, rl});
      wr(UDT_OFS_CNT, 32'hFFF0);
      wr(UDT_OFS_CTRL, 32'h4);
      wrap(65520, rl, 1'b1, 32'h84);
      chk({31'h0, n > ticks * 12 - 8 && n < ticks * 12 + 8}, 1);
      chk({31'h0, ovf_irq}, 32'h0);
      $display("test up done");
      wr(UDT_OFS_MODE, 32'h1);
      wr(UDT_OFS_CNT, {16'h0, rl + 16'h3});
      wr(UDT_OFS_CTRL, 32'h4);
      wrap(int'(rl) + 3, rl, 1'b0, 32'hC4);
      PM.dir(1'b1);
      wr(UDT_OFS_CNT, 32'hFFFE);
      wr(UDT_OFS_CTRL, 32'h4);
      wrap(65534, rl, 1'b1, 32'hC4);
      $display("test updown done");
      wr(UDT_OFS_MODE, 32'h0);
      wr(UDT_OFS_CNT, 32'h0);
      wr(UDT_OFS_CTRL, 32'h6);
      seed = lfsr(seed);
      np = 3 + int'(seed[1:0]);
      PM.pulse(np, 2 + int'(seed[3:2]));
      repeat (8) @(posedge clk);
      wr(UDT_OFS_CTRL, 32'h0);
      rd(UDT_OFS_CNT, np);
      $display("test counter done");
      for (int i = 0; i < 2; i++) begin
         rl = i ? 16'hFFFF : 16'hFFF9;
         wr(UDT_OFS_MODE, 32'h2);
         wr(UDT_OFS_RLD, {16'h0, rl});
         wr(UDT_OFS_CNT, {16'h0, rl});
         // second run has baud off, so only clock-out keeps the flag clear
         wr(UDT_OFS_CTRL, i ? 32'h4 : 32'h14);
         // first wait drops the part-period left from an earlier run
         hold(pin_o);
         hold(pin_o);
         chk(n, 2 * (65536 - int'(rl)));
         hold(pin_o);
         chk(n, 2 * (65536 - int'(rl)));
         chk({31'h0, pin_oe}, 32'h1);
         chk({31'h0, ovf_irq}, 32'h0);
         if (i == 0) begin
            n = 0;
            while (baud_tick !== 1'b1 && n < 300) begin
               @(posedge clk);
               n++;
            end
            chk({31'h0, baud_tick}, 32'h1);
         end
         wr(UDT_OFS_CTRL, 32'h0);
      end
      $display("test clock out done");
      close_out;
   end
endmodule
